//--- core/debug_serial_memory_access_cmds.sv
// Notes on behaviour
// - block read status: 0x33/37/3B, status then data
// - block read needs prior single read
// - block read uses pointer, then adds size
// - block read only after null/read/block read
// - size field decoded on every block command
// - status byte sampled after memory access
// - block write status: 0x13/17/1B, data then status
// - block write needs prior single write
// - block write uses pointer, then adds size
// - block write only after null/write/block write
// - resume leaves halt, restarts core prefetch
// - core uses values changed while halted
// - resume while running does nothing; here it still pulses the acknowledge and clears the block predecessor
// - null command does nothing but pulse the acknowledge
// - cpu register read returns 32 bits halted
// - cpu register read rejected when running
// - narrow cpu registers padded to 32 bits
// - debug register read allowed any time
// - single read codes, data msb first
// - word and long addresses aligned
// - access attributes from attribute register
// - acknowledge pulse when handshake enabled
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module debug_serial_memory_access_cmds #(
  parameter int CREG_W = 32
) (
  // clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  // received bytes from the serial shifter
  input  wire logic                            rx_valid,
  input  wire logic [7:0]                      rx_data,
  // bytes to send back
  output logic                                 tx_valid,
  output logic [7:0]                           tx_data,
  input  wire logic                            tx_ready,
  // handshake and error
  input  wire logic                            ack_enable,
  output logic                                 ack_pulse,
  output logic                                 illegal_cmd,
  // memory access port
  output logic                                 mem_req,
  output logic                                 mem_we,
  output logic [bdm_cmd_pkg::ADDR_W-1:0]       mem_addr,
  output logic [1:0]                           mem_size,
  output logic [31:0]                          mem_wdata,
  output logic [bdm_cmd_pkg::TT_W-1:0]         mem_tt,
  output logic [bdm_cmd_pkg::TM_W-1:0]         mem_tm,
  input  wire logic                            mem_ack,
  input  wire logic [31:0]                     mem_rdata,
  // debug access attribute register fields
  input  wire logic [bdm_cmd_pkg::TT_W-1:0]    transfer_type_field,
  input  wire logic [bdm_cmd_pkg::TM_W-1:0]    transfer_modifier_field,
  // core and debug register files
  input  wire logic                            cpu_halted,
  output logic                                 resume_req,
  output logic [bdm_cmd_pkg::CRN_W-1:0]        core_register_number,
  input  wire logic [CREG_W-1:0]               cpu_ctrl_rdata,
  input  wire logic [31:0]                     debug_ctrl_rdata,
  input  wire logic [31:0]                     extended_status_register
);
  import bdm_cmd_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_mem(input logic [7:0] c);
    return (c[7:4] == MEM_READ_GRP || c[7:4] == MEM_WRITE_GRP);
  endfunction : is_mem

  function automatic logic [2:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SZ_WORD: size_bytes = 3'h2;
      SZ_LONG: size_bytes = 3'h4;
      default: size_bytes = 3'h1;
    endcase
  endfunction : size_bytes

  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                              input logic [1:0] sz);
    case (sz)
      SZ_WORD: align = {a[ADDR_W-1:1], 1'b0};
      SZ_LONG: align = {a[ADDR_W-1:2], 2'h0};
      default: align = a;
    endcase
  endfunction : align

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t             state;
  prev_kind_t         prev_kind;
  logic [7:0]         cmd;
  logic [2:0]         cnt;
  logic [4:0]         dly_cnt;
  logic [ADDR_W-1:0]  addr_sh;
  logic [ADDR_W-1:0]  ptr;
  logic [31:0]        rdata;
  logic [39:0]        out_buf;

  logic [1:0]         in_sz;
  logic               in_block;
  logic               in_write;
  logic               in_legal_block;
  logic [1:0]         cmd_sz;
  logic               cmd_mem;
  logic               cmd_status;
  logic [31:0]        data_al;
  logic [31:0]        creg_pad;

  // size is always taken from the byte in hand, never carried over
  assign in_sz          = rx_data[SZ_LSB+1:SZ_LSB];
  assign in_block       = rx_data[BLOCK_BIT];
  assign in_write       = (rx_data[7:4] == MEM_WRITE_GRP);
  assign in_legal_block = in_write ? (prev_kind == PREV_WRITE)
                                   : (prev_kind == PREV_READ);
  assign cmd_sz         = cmd[SZ_LSB+1:SZ_LSB];
  assign cmd_mem        = is_mem(cmd);
  assign cmd_status     = cmd_mem && cmd[STATUS_BIT];
  assign core_register_number = cmd[CRN_W-1:0];
  assign creg_pad       = 32'(cpu_ctrl_rdata);

  // byte, word and long data are sent msb first from the top of out_buf
  always_comb begin
    case (cmd_sz)
      SZ_BYTE: data_al = {rdata[7:0], 24'h0};
      SZ_WORD: data_al = {rdata[15:0], 16'h0};
      default: data_al = rdata;
    endcase
  end

  assign tx_valid = (state == ST_SEND);
  assign tx_data  = out_buf[39:32];

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      cmd         <= NOP_CODE;
      cnt         <= 3'h0;
      dly_cnt     <= 5'h0;
      addr_sh     <= '0;
      mem_wdata   <= 32'h0;
      out_buf     <= 40'h0;
      illegal_cmd <= 1'b0;
      resume_req  <= 1'b0;
    end else begin
      illegal_cmd <= 1'b0;
      resume_req  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (rx_valid) begin
            cmd <= rx_data;
            if (rx_data == NOP_CODE) begin
              state <= ST_DONE;
            end else if (rx_data == GO_CODE) begin
              // the core flushes its pipeline and restarts from its own
              // current program counter and status, debug edits included
              resume_req <= cpu_halted;
              state      <= ST_DONE;
            end else if (is_mem(rx_data) && in_sz != SZ_BAD) begin
              if (!in_block) begin
                cnt   <= ADDR_BYTES;
                state <= ST_ADDR;
              end else if (!in_legal_block) begin
                illegal_cmd <= 1'b1;
                state       <= ST_DONE;
              end else if (in_write) begin
                cnt       <= size_bytes(in_sz);
                mem_wdata <= 32'h0;
                state     <= ST_WDATA;
              end else begin
                state <= ST_MEMOP;
              end
            end else if (rx_data[7:5] == CREG_GRP) begin
              if (cpu_halted) begin
                dly_cnt <= RESP_DELAY_CYC;
                state   <= ST_DELAY;
              end else begin
                illegal_cmd <= 1'b1;
                state       <= ST_DONE;
              end
            end else if (rx_data[7:5] == DREG_GRP) begin
              dly_cnt <= RESP_DELAY_CYC;
              state   <= ST_DELAY;
            end else begin
              // bad size codes illegal; other commands served elsewhere
              illegal_cmd <= is_mem(rx_data);
              state       <= ST_DONE;
            end
          end
        end
        ST_ADDR: begin
          if (rx_valid) begin
            addr_sh <= {addr_sh[ADDR_W-9:0], rx_data};
            cnt     <= cnt - 3'h1;
            if (cnt == 3'h1) begin
              if (cmd[7:4] == MEM_WRITE_GRP) begin
                // write data stays right justified, upper bytes zero
                cnt       <= size_bytes(cmd_sz);
                mem_wdata <= 32'h0;
                state     <= ST_WDATA;
              end else begin
                state <= ST_MEMOP;
              end
            end
          end
        end
        ST_WDATA: begin
          if (rx_valid) begin
            mem_wdata <= {mem_wdata[23:0], rx_data};
            cnt       <= cnt - 3'h1;
            if (cnt == 3'h1) begin
              state <= ST_MEMOP;
            end
          end
        end
        ST_MEMOP: begin
          if (mem_ack) begin
            dly_cnt <= RESP_DELAY_CYC;
            state   <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          dly_cnt <= dly_cnt - 5'h1;
          if (dly_cnt == 5'h1) begin
            state <= ST_SEND;
            cnt   <= 3'h4;
            if (cmd[7:5] == CREG_GRP) begin
              out_buf <= {creg_pad, 8'h0};
            end else if (cmd[7:5] == DREG_GRP) begin
              out_buf <= {debug_ctrl_rdata, 8'h0};
            end else if (cmd[7:4] == MEM_WRITE_GRP) begin
              // status sampled now, well after the write finished
              out_buf <= {extended_status_register[ESR_SB_MSB:ESR_SB_LSB], 32'h0};
              cnt     <= 3'h1;
              state   <= cmd_status ? ST_SEND : ST_DONE;
            end else if (cmd_status) begin
              out_buf <= {extended_status_register[ESR_SB_MSB:ESR_SB_LSB], data_al};
              cnt     <= size_bytes(cmd_sz) + 3'h1;
            end else begin
              out_buf <= {data_al, 8'h0};
              cnt     <= size_bytes(cmd_sz);
            end
          end
        end
        ST_SEND: begin
          if (tx_ready) begin
            out_buf <= {out_buf[31:0], 8'h0};
            cnt     <= cnt - 3'h1;
            if (cnt == 3'h1) begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // memory port and address pointer
  // ---------------------------------------------------------------
  // the pointer advances only on a finished access, so padding nulls
  // between block commands never disturb it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr      <= '0;
      mem_req  <= 1'b0;
      mem_we   <= 1'b0;
      mem_addr <= '0;
      mem_size <= SZ_BYTE;
      mem_tt   <= '0;
      mem_tm   <= '0;
      rdata    <= 32'h0;
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
        rdata   <= mem_rdata;
        ptr     <= mem_addr + {{(ADDR_W-3){1'b0}}, size_bytes(mem_size)};
      end
    end else if ((state == ST_ADDR || state == ST_WDATA) && rx_valid && cnt == 3'h1
                 && !(state == ST_ADDR && cmd[7:4] == MEM_WRITE_GRP)) begin
      mem_req  <= 1'b1;
      mem_we   <= (cmd[7:4] == MEM_WRITE_GRP);
      mem_size <= cmd_sz;
      mem_tt   <= transfer_type_field;
      mem_tm   <= transfer_modifier_field;
      mem_addr <= cmd[BLOCK_BIT] ? align(ptr, cmd_sz)
                : (state == ST_ADDR) ? align({addr_sh[ADDR_W-9:0], rx_data}, cmd_sz)
                : align(addr_sh, cmd_sz);
    end else if (state == ST_IDLE && rx_valid && is_mem(rx_data) && in_sz != SZ_BAD
                 && in_block && in_legal_block && !in_write) begin
      mem_req  <= 1'b1;
      mem_we   <= 1'b0;
      mem_size <= in_sz;
      mem_tt   <= transfer_type_field;
      mem_tm   <= transfer_modifier_field;
      mem_addr <= align(ptr, in_sz);
    end
  end

  // ---------------------------------------------------------------
  // predecessor tracking and handshake
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_kind <= PREV_OTHER;
      ack_pulse <= 1'b0;
    end else begin
      ack_pulse <= 1'b0;
      if (state == ST_DONE) begin
        // status variants of memory commands carry no acknowledge
        ack_pulse <= ack_enable && !illegal_cmd && !cmd_status;
        if (illegal_cmd) begin
          prev_kind <= PREV_OTHER;
        end else if (cmd == NOP_CODE) begin
          prev_kind <= prev_kind;
        end else if (cmd_mem) begin
          prev_kind <= (cmd[7:4] == MEM_WRITE_GRP) ? PREV_WRITE : PREV_READ;
        end else begin
          prev_kind <= PREV_OTHER;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_block_read_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && rx_valid && rx_data[7:4] == MEM_READ_GRP && rx_data[BLOCK_BIT]
     && rx_data[3:2] != SZ_BAD && prev_kind != PREV_READ) |=> illegal_cmd && !mem_req)
    else $error("block read accepted without a read before it");

  a_block_write_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && rx_valid && rx_data[7:4] == MEM_WRITE_GRP && rx_data[BLOCK_BIT]
     && rx_data[3:2] != SZ_BAD && prev_kind != PREV_WRITE) |=> illegal_cmd ##1 state == ST_IDLE)
    else $error("block write accepted without a write before it");

  a_ptr_advance: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_req && mem_ack) |=>
      ptr == $past(mem_addr) + {{(ADDR_W-3){1'b0}}, size_bytes($past(mem_size))})
    else $error("pointer not advanced by operand size");

  a_addr_align: assert property (@(posedge sys_clk) disable iff (rst)
    mem_req |-> (mem_size == SZ_BYTE) || (mem_size == SZ_WORD && !mem_addr[0])
                || (mem_size == SZ_LONG && mem_addr[1:0] == 2'h0))
    else $error("memory access not aligned to its size");

  a_attr_copy: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(mem_req) |-> mem_tt == $past(transfer_type_field)
                       && mem_tm == $past(transfer_modifier_field))
    else $error("access attributes not taken from attribute register");

  a_resume_halted: assert property (@(posedge sys_clk) disable iff (rst)
    resume_req |-> $past(cpu_halted) && $past(rx_data) == GO_CODE)
    else $error("resume issued while core running");

  a_creg_reject: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && rx_valid && rx_data[7:5] == CREG_GRP && !cpu_halted)
      |=> illegal_cmd && state == ST_DONE ##1 !tx_valid)
    else $error("cpu register read not rejected while running");

  a_null_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && rx_valid && rx_data == NOP_CODE)
      |=> (ptr == $past(ptr)) && !mem_req && !illegal_cmd ##1 prev_kind == $past(prev_kind, 2))
    else $error("null command changed state");

  a_reply_delay: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state == ST_DELAY) |-> (!tx_valid)[*8])
    else $error("reply started before delay elapsed");

  a_ack_gate: assert property (@(posedge sys_clk) disable iff (rst)
    ack_pulse |-> $past(ack_enable) && !$past(cmd_status) && $past(state) == ST_DONE)
    else $error("acknowledge pulse without handshake enabled");

endmodule : debug_serial_memory_access_cmds

//--- core/bdm_cmd_pkg.sv
package bdm_cmd_pkg;
  // ---------------------------------------------------------------
  // command codes and groups
  // ---------------------------------------------------------------
  localparam logic [7:0] NOP_CODE      = 8'h00;
  localparam logic [7:0] GO_CODE       = 8'h08;
  localparam logic [3:0] MEM_WRITE_GRP = 4'h1;
  localparam logic [3:0] MEM_READ_GRP  = 4'h3;
  localparam logic [2:0] CREG_GRP      = 3'h7;
  localparam logic [2:0] DREG_GRP      = 3'h5;
  localparam int         BLOCK_BIT     = 1;
  localparam int         STATUS_BIT    = 0;
  localparam int         SZ_LSB        = 2;
  localparam logic [1:0] SZ_BYTE       = 2'h0;
  localparam logic [1:0] SZ_WORD       = 2'h1;
  localparam logic [1:0] SZ_LONG       = 2'h2;
  localparam logic [1:0] SZ_BAD        = 2'h3;
  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 24;
  localparam int CRN_W      = 5;
  localparam int TT_W       = 2;
  localparam int TM_W       = 3;
  localparam int ESR_SB_MSB = 31;
  localparam int ESR_SB_LSB = 24;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [4:0] RESP_DELAY_CYC = 5'h10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PREV_OTHER = 2'b00,
    PREV_READ  = 2'b01,
    PREV_WRITE = 2'b10
  } prev_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WDATA = 3'b010,
    ST_MEMOP = 3'b011,
    ST_DELAY = 3'b100,
    ST_SEND  = 3'b101,
    ST_DONE  = 3'b110
  } state_t;
endpackage : bdm_cmd_pkg

//--- sim/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // memory port of the block
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata = 32'h0,
  // test control
  input  wire logic        slow
);
  logic [7:0]  mem [256];
  logic [3:0]  wait_cnt;
  logic        served;
  logic [31:0] rd;
  int          n;

  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 13 + 7);

  // -------------------------------------------------------------
  // one answer per request, prompt or after five idle cycles
  // -------------------------------------------------------------
  always @(posedge sys_clk) begin
    n = 1 << mem_size;
    mem_ack <= 1'b0;
    // outside an answer the data lines toggle, so stale data never looks valid
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_cnt <= 4'h0;
      served <= 1'b0;
    end else if (mem_req && !served) begin
      if (wait_cnt == (slow ? 4'h5 : 4'h0)) begin
        mem_ack <= 1'b1;
        served <= 1'b1;
        wait_cnt <= 4'h0;
        rd = '0;
        for (int i = 0; i < n; i++) begin
          if (mem_we) mem[8'(mem_addr + i)] = mem_wdata[8 * (n - 1 - i) +: 8];
          rd = {rd[23:0], mem[8'(mem_addr + i)]};
        end
        if (!mem_we) mem_rdata <= rd;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else if (!mem_req) begin
      served <= 1'b0;
    end
  end
endmodule : mem_model

//--- sim/debug_serial_memory_access_cmds_test.sv
`timescale 1ns/1ps
module debug_serial_memory_access_cmds_test;
  import bdm_cmd_pkg::*;
  // -------------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, tx_ready = 1'b0, ack_enable = 1'b1;
  logic cpu_halted = 1'b1, slow = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic [1:0]  tt = 2'h2;
  logic [2:0]  tm = 3'h5;
  logic [31:0] creg = 32'h8765_4321, dreg = 32'h0BAD_F00D, esr = 32'hC300_0000;
  logic tx_valid, ack_pulse, illegal_cmd, mem_req, mem_we, mem_ack, resume_req;
  logic [7:0]  tx_data;
  logic [23:0] mem_addr, req_addr;
  logic [1:0]  mem_size, mem_tt, req_size;
  logic [2:0]  mem_tm;
  logic [31:0] mem_wdata, mem_rdata, req_wdata;
  logic [4:0]  core_register_number;
  logic [4:0]  req_attr;
  logic        req_we, req_q = 1'b0;
  logic [7:0]  shadow [256];
  int err_count = 0, samples_checked = 0, cycles = 0;
  int ill_cnt = 0, ack_cnt = 0, go_cnt = 0, req_cnt = 0;

  always #25 sys_clk = ~sys_clk;

  debug_serial_memory_access_cmds debug_serial_memory_access_cmds_i (
    .sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .ack_enable(ack_enable), .ack_pulse(ack_pulse), .illegal_cmd(illegal_cmd),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_tt(mem_tt), .mem_tm(mem_tm), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .transfer_type_field(tt), .transfer_modifier_field(tm),
    .cpu_halted(cpu_halted), .resume_req(resume_req),
    .core_register_number(core_register_number), .cpu_ctrl_rdata(creg),
    .debug_ctrl_rdata(dreg), .extended_status_register(esr));

  mem_model mem_model_i (
    .sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slow(slow));

  // -------------------------------------------------------------
  // watchers: pulse counts and the attributes of each request
  // -------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (illegal_cmd === 1'b1) ill_cnt++;
    if (ack_pulse === 1'b1) ack_cnt++;
    if (resume_req === 1'b1) go_cnt++;
    if (mem_req === 1'b1 && !req_q) begin
      req_cnt++;
      {req_addr, req_size, req_we, req_wdata, req_attr} =
        {mem_addr, mem_size, mem_we, mem_wdata, mem_tt, mem_tm};
    end
    req_q = (mem_req === 1'b1);
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // a gap cycle after each byte keeps rx_valid to one assignment per step
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : send

  task automatic recv(output logic [7:0] b, input int stall);
    int n = 0;
    @(negedge sys_clk);
    while (tx_valid !== 1'b1 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 200) err_count++;
    repeat (stall) @(negedge sys_clk);
    b = tx_data;
    @(posedge sys_clk);
    tx_ready <= 1'b1;
    @(posedge sys_clk);
    tx_ready <= 1'b0;
  endtask : recv

  task automatic cmd(input logic [7:0] code, input int na, input logic [23:0] a, input int nw,
                     input logic [31:0] wd, input int nr, output logic [39:0] got);
    logic [7:0] b;
    got = '0;
    send(code);
    for (int i = na - 1; i >= 0; i--) send(a[8 * i +: 8]);
    for (int i = nw - 1; i >= 0; i--) send(wd[8 * i +: 8]);
    for (int i = 0; i < nr; i++) begin
      recv(b, i);
      got = {got[31:0], b};
    end
    repeat (nr > 0 ? 4 : 40) @(posedge sys_clk);
  endtask : cmd

  function automatic logic [39:0] exp_rd(input int ws, input logic [23:0] a,
                                         input logic [1:0] sz);
    logic [39:0] v = '0;
    for (int i = 0; i < (1 << sz); i++) v = {v[31:0], shadow[8'(a + i)]};
    if (ws != 0) v = v | (40'(esr[31:24]) << (8 << sz));
    return v;
  endfunction : exp_rd

  task automatic wr(input logic [23:0] a, input int n, input logic [31:0] d);
    for (int i = 0; i < n; i++) shadow[8'(a + i)] = d[8 * (n - 1 - i) +: 8];
  endtask : wr

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_single_read;
    logic [39:0] got;
    logic [23:0] al;
    int a0;
    for (int sz = 0; sz < 3; sz++) begin
      for (int ws = 0; ws < 2; ws++) begin
        a0 = ack_cnt;
        esr <= {8'(8'hA0 + 2 * sz + ws), 24'h0};
        al = 24'(8'h13 + 16 * sz) & ~24'((1 << sz) - 1);
        cmd(8'(8'h30 + 4 * sz + ws), 3, 24'(8'h13 + 16 * sz), 0, 0, (1 << sz) + ws, got);
        check(req_addr, al);
        check({req_we, req_size}, {1'b0, 2'(sz)});
        check(req_attr, {tt, tm});
        check(got, exp_rd(ws, al, 2'(sz)));
        check(ack_cnt - a0, (ws != 0) ? 0 : 1);
      end
    end
  endtask : t_single_read

  task automatic t_block_read;
    logic [39:0] got;
    int i0;
    cmd(8'hA2, 0, 0, 0, 0, 4, got);
    i0 = ill_cnt;
    cmd(8'h33, 0, 0, 0, 0, 0, got);
    check(ill_cnt - i0, 1);
    check(tx_valid, 1'b0);
    cmd(8'h30, 3, 24'h000020, 0, 0, 1, got);
    cmd(8'h33, 0, 0, 0, 0, 2, got);
    check({req_addr, got}, {24'h000021, exp_rd(1, 24'h000021, SZ_BYTE)});
    i0 = req_cnt;
    cmd(NOP_CODE, 0, 0, 0, 0, 0, got);
    check(req_cnt - i0, 0);
    cmd(8'h37, 0, 0, 0, 0, 3, got);
    check({req_addr, req_size, got}, {24'h000022, SZ_WORD, exp_rd(1, 24'h22, SZ_WORD)});
    cmd(8'h3B, 0, 0, 0, 0, 5, got);
    check({req_addr, req_size, got}, {24'h000024, SZ_LONG, exp_rd(1, 24'h24, SZ_LONG)});
    cmd(8'h32, 0, 0, 0, 0, 1, got);
    check({req_addr, got}, {24'h000028, exp_rd(0, 24'h28, SZ_BYTE)});
    i0 = ill_cnt;
    cmd(8'hA3, 0, 0, 0, 0, 4, got);
    cmd(8'h33, 0, 0, 0, 0, 0, got);
    check(ill_cnt - i0, 1);
  endtask : t_block_read

  task automatic t_block_write;
    logic [39:0] got;
    int i0;
    i0 = ill_cnt;
    cmd(8'h13, 0, 0, 1, 8'h99, 0, got);
    check(ill_cnt - i0, 1);
    cmd(8'h14, 3, 24'h000041, 2, 16'hA1B2, 0, got);
    wr(24'h40, 2, 16'hA1B2);
    check({req_addr, req_we}, {24'h000040, 1'b1});
    cmd(8'h17, 0, 0, 2, 16'h1122, 1, got);
    wr(24'h42, 2, 16'h1122);
    check({req_addr, req_wdata, got}, {24'h42, 32'h1122, 40'(esr[31:24])});
    cmd(8'h1B, 0, 0, 4, 32'h3344_5566, 1, got);
    wr(24'h44, 4, 32'h3344_5566);
    check({req_addr, req_size, req_wdata}, {24'h44, SZ_LONG, 32'h3344_5566});
    cmd(8'h12, 0, 0, 1, 8'h77, 0, got);
    wr(24'h48, 1, 8'h77);
    check({req_addr, req_size}, {24'h48, SZ_BYTE});
    cmd(8'h38, 3, 24'h000044, 0, 0, 4, got);
    check(got, exp_rd(0, 24'h44, SZ_LONG));
    cmd(8'h34, 3, 24'h000048, 0, 0, 2, got);
    check(got, exp_rd(0, 24'h48, SZ_WORD));
    i0 = ill_cnt;
    cmd(8'h13, 0, 0, 1, 8'h55, 0, got);
    check(ill_cnt - i0, 1);
  endtask : t_block_write

  task automatic t_regs_go;
    logic [39:0] got;
    int i0;
    cmd(8'hE5, 0, 0, 0, 0, 4, got);
    check({core_register_number, got}, {5'h05, 40'(creg)});
    cpu_halted <= 1'b0;
    i0 = ill_cnt;
    cmd(8'hE5, 0, 0, 0, 0, 0, got);
    check({ill_cnt - i0, 31'(tx_valid)}, {32'd1, 31'd0});
    cmd(8'hA2, 0, 0, 0, 0, 4, got);
    check(got, dreg);
    i0 = go_cnt;
    cmd(GO_CODE, 0, 0, 0, 0, 0, got);
    check(go_cnt - i0, 0);
    cpu_halted <= 1'b1;
    cmd(GO_CODE, 0, 0, 0, 0, 0, got);
    check(go_cnt - i0, 1);
    ack_enable <= 1'b0;
    i0 = ack_cnt;
    cmd(NOP_CODE, 0, 0, 0, 0, 0, got);
    check(ack_cnt - i0, 0);
    ack_enable <= 1'b1;
    cmd(NOP_CODE, 0, 0, 0, 0, 0, got);
    check(ack_cnt - i0, 1);
  endtask : t_regs_go

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 13 + 7);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_single_read();
    t_block_read();
    slow <= 1'b1;
    t_block_write();
    t_regs_go();
    summarize();
  end
endmodule : debug_serial_memory_access_cmds_test
